// >>> bench/tb_pwm_time_base.sv
// self-checking bench for the pwm time base
`timescale 1ns/1ps
`default_nettype none
module tb_pwm_time_base;
    import ptb_pkg::*;
    // clock, reset and apb drive
    logic        pclk    = 1'b0;
    logic        presetn = 1'b0;
    logic        psel    = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite  = 1'b0;
    logic [7:0]  paddr   = 8'h00;
    logic [31:0] pwdata  = 32'h0;
    // design outputs
    logic        pready;
    logic [31:0] prdata;
    logic        pslverr;
    logic        period_match;
    logic        zero_detect;
    logic        adc_trigger;
    logic        irq;
    // bookkeeping
    int          mismatches = 0;
    int          tests_run  = 0;
    int          cyc        = 0;
    int          adc_n      = 0;
    int          t0;
    logic [15:0] lfsr       = 16'h003e;
    logic [31:0] rd;
    logic [31:0] c;
    logic        err_seen;
    logic        irq_seen;
    logic        s;

    ptb_time_base ptb_time_base_inst (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
        .prdata(prdata), .pslverr(pslverr), .period_match(period_match),
        .zero_detect(zero_detect), .adc_trigger(adc_trigger), .irq(irq));

    // clock and cycle / trigger counters
    always #50 pclk = ~pclk;
    always @(posedge pclk) begin
        cyc <= cyc + 1;
        if (adc_trigger === 1'b1) adc_n <= adc_n + 1;
    end

    // pseudo random source and tolerance test
    function automatic logic [15:0] lfsr_next(input logic [15:0] x);
        return {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
    endfunction
    function automatic logic near(input int v, input int e);
        return (v >= e - 2) && (v <= e + 2);
    endfunction

    task automatic check(input string what, input logic [31:0] seen,
                         input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            mismatches++;
            $display("MISMATCH %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic wrap_up;
        $display("checks %0d mismatches %0d", tests_run, mismatches);
        if (mismatches == 0 && tests_run > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    // one apb transfer, held until pready is sampled high
    task automatic apb(input logic wr, input logic [7:0] a,
                       input logic [31:0] d);
        psel   <= 1'b1;
        pwrite <= wr;
        paddr  <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) @(posedge pclk);
        rd       = prdata;
        err_seen = pslverr;
        irq_seen = irq;
        psel    <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask

    // run a mode, count flags seen by status polling and triggers seen on adc_trigger
    task automatic poll(input logic [1:0] m, input logic [3:0] ps,
                        input logic msk, input int ev_int, input int ad_int);
        int n;
        int a0;
        n = 0;
        apb(1'b1, OFF_CTRL, 32'h0);
        apb(1'b1, OFF_COUNT, 32'h0);
        apb(1'b1, OFF_MASK, {31'h0, msk});
        apb(1'b0, OFF_STATUS, 32'h0);
        apb(1'b1, OFF_CTRL, 32'h8000 | {ps, 2'b00, m});
        t0 = cyc;
        a0 = adc_n;
        repeat (60) begin
            apb(1'b0, OFF_STATUS, 32'h0);
            n += rd[ST_IRQ_BIT];
            check("irq", irq_seen, rd[ST_IRQ_BIT] & msk);
        end
        check("events", near(n, (cyc - t0) / ev_int), 1'b1);
        check("adc", near(adc_n - a0, (cyc - t0) / ad_int), 1'b1);
    endtask

    // watchdog
    initial begin
        repeat (20000) @(posedge pclk);
        mismatches++;
        wrap_up();
    end

    // main sequence
    initial begin
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        for (int a = 0; a < 28; a += 4) begin
            apb(1'b0, a[7:0], 32'h0);
            check("reset value", rd, 32'h0);
            check("slave error", err_seen, a == 24);
        end
        lfsr = lfsr_next(lfsr);
        apb(1'b1, OFF_COUNT, {16'h0, lfsr});
        apb(1'b0, OFF_COUNT, 32'h0);
        check("count width", rd, {17'h0, lfsr[14:0]});
        apb(1'b1, OFF_PERIOD, {16'h0, lfsr});
        repeat (1) @(posedge pclk);
        check("period match", period_match, 1'b1);
        check("zero detect", zero_detect, lfsr[14:0] == 0);
        apb(1'b1, OFF_COUNT, 32'h0);
        check("zero detect", zero_detect, 1'b1);
        check("period match", period_match, lfsr[14:0] == 0);
        // prescale ratios, stop keeps the count
        apb(1'b1, OFF_PERIOD, 32'h7fff);
        for (int p = 0; p < 4; p++) begin
            apb(1'b1, OFF_COUNT, 32'h0);
            apb(1'b1, OFF_CTRL, 32'h8000 | (p << 2));
            t0 = cyc;
            repeat (150) @(posedge pclk);
            apb(1'b1, OFF_CTRL, 32'h0);
            t0 = cyc - t0;
            apb(1'b0, OFF_COUNT, 32'h0);
            check("prescale", near(rd[14:0], t0 >> (2 * p)), 1'b1);
            c = rd;
            apb(1'b1, OFF_CTRL, 32'h2);
            apb(1'b0, OFF_COUNT, 32'h0);
            check("held count", rd, c);
        end
        // buffered period waits for the wrap while running at 1:64
        apb(1'b1, OFF_COUNT, 32'h0);
        apb(1'b1, OFF_PERIOD, 32'h5);
        apb(1'b1, OFF_CTRL, 32'h800c);
        apb(1'b1, OFF_PERIOD, 32'h3);
        repeat (280) @(posedge pclk);
        apb(1'b0, OFF_COUNT, 32'h0);
        check("period held", rd[14:0], 15'h4);
        repeat (379) @(posedge pclk);
        apb(1'b0, OFF_COUNT, 32'h0);
        check("period loaded", rd[14:0], 15'h0);
        apb(1'b1, OFF_CTRL, 32'h0);
        // single event: stop, clear, flag despite postscale
        apb(1'b1, OFF_PERIOD, 32'h5);
        apb(1'b1, OFF_COUNT, 32'h0);
        apb(1'b0, OFF_STATUS, 32'h0);
        apb(1'b1, OFF_CTRL, 32'h8031);
        repeat (12) @(posedge pclk);
        apb(1'b0, OFF_CTRL, 32'h0);
        check("run cleared", rd, 32'h0031);
        apb(1'b0, OFF_COUNT, 32'h0);
        check("single count", rd, 32'h0);
        apb(1'b0, OFF_STATUS, 32'h0);
        check("single event", rd[ST_IRQ_BIT], 1'b1);
        // up/down range and direction flag
        apb(1'b1, OFF_CTRL, 32'h8002);
        s = 1'b0;
        repeat (20) begin
            apb(1'b0, OFF_COUNT, 32'h0);
            s |= rd[CNT_DIR_BIT];
            check("updown range", rd[14:0] <= (rd[15] ? 4 : 5), 1'b1);
        end
        check("direction seen", s, 1'b1);
        // interrupt pacing in free-running, up/down and double modes; random postscale and mask in free-running runs only
        apb(1'b1, OFF_EVCMP, 32'h2);
        for (int k = 0; k < 4; k++) begin
            lfsr = lfsr_next(lfsr);
            poll(2'b00, {2'b00, lfsr[5:4]}, lfsr[8], 6 * (lfsr[5:4] + 1), 6);
        end
        poll(2'b10, 4'h0, 1'b1, 10, 5);
        poll(2'b11, 4'h7, 1'b1, 5, 5);
        wrap_up();
    end
endmodule
`default_nettype wire

// >>> logic/ptb_pkg.sv
// package for the pwm time base: offsets, fields, reset values
package ptb_pkg;
    // register byte offsets on the apb bus
    localparam logic [7:0] OFF_CTRL   = 8'h00;
    localparam logic [7:0] OFF_COUNT  = 8'h04;
    localparam logic [7:0] OFF_PERIOD = 8'h08;
    localparam logic [7:0] OFF_EVCMP  = 8'h0c;
    localparam logic [7:0] OFF_STATUS = 8'h10;
    localparam logic [7:0] OFF_MASK   = 8'h14;
    // control register field positions and count register direction bit
    localparam int CTRL_MODE_LSB  = 0;
    localparam int CTRL_PRE_LSB   = 2;
    localparam int CTRL_POST_LSB  = 4;
    localparam int CTRL_RUN_BIT   = 15;
    localparam int CNT_DIR_BIT    = 15;
    // status register bit positions
    localparam int ST_IRQ_BIT     = 0;
    localparam int ST_SEVT_BIT    = 1;
    // reset values
    localparam logic [15:0] CTRL_RESET   = 16'h0000;
    localparam logic [14:0] COUNT_RESET  = 15'h0000;
    localparam logic [14:0] PERIOD_RESET = 15'h0000;
    localparam logic [14:0] EVCMP_RESET  = 15'h0000;
    localparam logic [1:0]  MASK_RESET   = 2'h0;
    // prescaler terminal counts for 1:1, 1:4, 1:16, 1:64
    localparam logic [5:0] PRE_TC1  = 6'h00;
    localparam logic [5:0] PRE_TC4  = 6'h03;
    localparam logic [5:0] PRE_TC16 = 6'h0f;
    localparam logic [5:0] PRE_TC64 = 6'h3f;
    // counting modes
    typedef enum logic [1:0] {
        MODE_FREE   = 2'b00,
        MODE_SINGLE = 2'b01,
        MODE_UPDN   = 2'b10,
        MODE_UPDN2  = 2'b11
    } ptb_mode_type;
endpackage

// >>> logic/ptb_time_base.sv
// pwm time base: counter, prescaler, postscaler, period buffer, apb slave
//
// The implementer's own choices: the APB register port and the register offsets.
`timescale 1ns/1ps
`default_nettype none

// Notes on behaviour
// [R1] free-running: count up, clear after match
// [R2] single event: clear and stop after match
// [R3] up/down: reverse at period, up at zero
// [R4] count register bit 15 shows down direction
// [R5] double update: events at zero and match
// [R6] counter is fifteen bits wide
// [R7] prescale input clock by 1, 4, 16, 64
// [R8] prescaler cleared by count/control write, reset
// [R9] control write keeps counter value
// [R10] period match when count equals active period
// [R11] zero detect when count equals zero
// [R12] stopping keeps the count value
// [R13] postscaler 1:1 to 1:16 paces flag
// [R14] postscaler cleared by count/control write, reset
// [R15] buffered period loads at cycle boundary
// [R16] period loads at once while stopped
// [R17] event trigger when count hits compare value
// [R18] single and double modes bypass postscaler
// [R19] counter moves only on prescaler pulse
module ptb_time_base
    import ptb_pkg::*;
#(
    parameter int CW = 15
) (
    // clock and reset
    input  wire logic        pclk,
    input  wire logic        presetn,
    // apb slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic             pready,
    output logic [31:0]      prdata,
    output logic             pslverr,
    // time base events
    output logic             period_match,
    output logic             zero_detect,
    output logic             adc_trigger,
    output logic             irq
);

    // control fields and state
    logic [15:0]   ctrl_q;
    logic [CW-1:0] count_q;
    logic          dir_q;
    logic [CW-1:0] period_buf_q;
    logic [CW-1:0] period_act_q;
    logic [CW-1:0] evcmp_q;
    logic [5:0]    pre_q;
    logic [3:0]    post_q;
    logic [1:0]    status_q;
    logic [1:0]    mask_q;
    logic          adc_trigger_q;

    ptb_mode_type mode;
    logic         run;
    logic [1:0]   pre_sel;
    logic [3:0]   post_sel;
    logic         wr_en;
    logic         rd_en;
    logic         wr_ctrl;
    logic         wr_count;
    logic         wr_period;
    logic         wr_evcmp;
    logic         wr_mask;
    logic         rd_status;
    logic         addr_ok;
    logic [5:0]   pre_tc;
    logic         tick;
    logic         event_raw;
    logic         post_hit;
    logic         irq_event;
    logic         updn;
    logic         single_stop;

    assign mode     = ptb_mode_type'(ctrl_q[CTRL_MODE_LSB +: 2]);
    assign run      = ctrl_q[CTRL_RUN_BIT];
    assign pre_sel  = ctrl_q[CTRL_PRE_LSB +: 2];
    assign post_sel = ctrl_q[CTRL_POST_LSB +: 4];
    assign updn     = mode[1];

    // apb strobes, zero wait state
    assign pready   = 1'b1;
    assign wr_en    = psel && penable && pwrite;
    assign rd_en    = psel && penable && !pwrite;

    // address decode
    always_comb begin
        addr_ok   = 1'b1;
        wr_ctrl   = 1'b0;
        wr_count  = 1'b0;
        wr_period = 1'b0;
        wr_evcmp  = 1'b0;
        wr_mask   = 1'b0;
        rd_status = 1'b0;
        if (paddr == OFF_CTRL) begin
            wr_ctrl = wr_en;
        end else if (paddr == OFF_COUNT) begin
            wr_count = wr_en;
        end else if (paddr == OFF_PERIOD) begin
            wr_period = wr_en;
        end else if (paddr == OFF_EVCMP) begin
            wr_evcmp = wr_en;
        end else if (paddr == OFF_STATUS) begin
            rd_status = rd_en;
        end else if (paddr == OFF_MASK) begin
            wr_mask = wr_en;
        end else begin
            addr_ok = 1'b0;
        end
    end

    // unmapped addresses answer with an error
    assign pslverr = psel && penable && !addr_ok;

    // read data mux
    always_comb begin
        prdata = 32'h0000_0000;
        if (paddr == OFF_CTRL) begin
            prdata[15:0] = ctrl_q;
        end else if (paddr == OFF_COUNT) begin
            prdata[CW-1:0]     = count_q;
            prdata[CNT_DIR_BIT] = dir_q; // R4
        end else if (paddr == OFF_PERIOD) begin
            prdata[CW-1:0] = period_buf_q;
        end else if (paddr == OFF_EVCMP) begin
            prdata[CW-1:0] = evcmp_q;
        end else if (paddr == OFF_STATUS) begin
            prdata[1:0] = status_q;
        end else if (paddr == OFF_MASK) begin
            prdata[1:0] = mask_q;
        end else begin
            prdata = 32'h0000_0000;
        end
    end

    // comparators on the live count
    assign period_match = (count_q == period_act_q); // R10
    assign zero_detect  = (count_q == '0);           // R11

    // prescaler terminal count select
    always_comb begin
        case (pre_sel) // R7
            2'b00:   pre_tc = PRE_TC1;
            2'b01:   pre_tc = PRE_TC4;
            2'b10:   pre_tc = PRE_TC16;
            default: pre_tc = PRE_TC64;
        endcase
    end

    // a control write restarts the prescaler, so no step in that cycle
    assign tick = run && !wr_ctrl && (pre_q == pre_tc); // R19 R9

    // input prescaler counter
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pre_q <= 6'h00; // R8
        end else if (wr_count || wr_ctrl || !run) begin
            pre_q <= 6'h00; // R8
        end else if (pre_q == pre_tc) begin
            pre_q <= 6'h00;
        end else begin
            pre_q <= pre_q + 6'h01;
        end
    end

    // hardware stop at the end of a single event period
    assign single_stop = tick && (mode == MODE_SINGLE) && period_match;

    // control register; hardware clears run in single event mode
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_q <= CTRL_RESET;
        end else if (wr_ctrl) begin
            ctrl_q <= pwdata[15:0];
        end else if (single_stop) begin
            ctrl_q[CTRL_RUN_BIT] <= 1'b0; // R2
        end
    end

    // counter and direction; control writes leave them alone
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            count_q <= COUNT_RESET;
            dir_q   <= 1'b0;
        end else if (wr_count) begin
            count_q <= pwdata[CW-1:0];
        end else if (tick) begin // R9 R12
            if (!updn) begin
                dir_q <= 1'b0;
                if (period_match) begin
                    count_q <= '0; // R1 R2
                end else begin
                    count_q <= count_q + 1'b1; // R6
                end
            end else if (!dir_q) begin
                if (period_match && !zero_detect) begin
                    dir_q   <= 1'b1; // R3 R4
                    count_q <= count_q - 1'b1;
                end else if (period_match) begin
                    count_q <= count_q;
                end else begin
                    count_q <= count_q + 1'b1; // R3
                end
            end else begin
                if (zero_detect) begin
                    dir_q   <= 1'b0; // R3
                    count_q <= count_q + 1'b1;
                end else begin
                    count_q <= count_q - 1'b1;
                end
            end
        end
    end

    // period buffer and hidden active period
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            period_buf_q <= PERIOD_RESET;
            period_act_q <= PERIOD_RESET;
        end else begin
            if (wr_period) begin
                period_buf_q <= pwdata[CW-1:0];
            end
            if (!run) begin
                period_act_q <= period_buf_q; // R16
            end else if (tick && !updn && period_match) begin
                period_act_q <= period_buf_q; // R15
            end else if (tick && updn && zero_detect) begin
                period_act_q <= period_buf_q; // R15
            end
        end
    end

    // raw interrupt events per mode
    always_comb begin
        event_raw = 1'b0;
        case (mode)
            MODE_FREE:   event_raw = tick && period_match; // R1
            MODE_SINGLE: event_raw = tick && period_match; // R2
            MODE_UPDN:   event_raw = tick && zero_detect && dir_q;
            default:     event_raw = tick && (zero_detect || period_match); // R5
        endcase
    end

    assign post_hit  = (post_q == post_sel);
    assign irq_event = event_raw &&
        ((mode == MODE_SINGLE) || (mode == MODE_UPDN2) || post_hit); // R18

    // output postscaler counter
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            post_q <= 4'h0; // R14
        end else if (wr_count || wr_ctrl) begin
            post_q <= 4'h0; // R14
        end else if (event_raw && post_hit) begin
            post_q <= 4'h0; // R13
        end else if (event_raw) begin
            post_q <= post_q + 4'h1; // R13
        end
    end

    // event compare register and trigger pulse
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            evcmp_q       <= EVCMP_RESET;
            adc_trigger_q <= 1'b0;
        end else begin
            if (wr_evcmp) begin
                evcmp_q <= pwdata[CW-1:0];
            end
            adc_trigger_q <= tick && (count_q == evcmp_q); // R17
        end
    end

    assign adc_trigger = adc_trigger_q;

    // sticky status, cleared by read, set wins
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            status_q <= 2'h0;
        end else begin
            if (irq_event) begin
                status_q[ST_IRQ_BIT] <= 1'b1; // R13
            end else if (rd_status) begin
                status_q[ST_IRQ_BIT] <= 1'b0;
            end
            if (tick && (count_q == evcmp_q)) begin
                status_q[ST_SEVT_BIT] <= 1'b1;
            end else if (rd_status) begin
                status_q[ST_SEVT_BIT] <= 1'b0;
            end
        end
    end

    // interrupt mask register
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mask_q <= MASK_RESET;
        end else if (wr_mask) begin
            mask_q <= pwdata[1:0];
        end
    end

    assign irq = |(status_q & mask_q);

    // checks
    sequence up_at_period_s;
        tick && updn && !dir_q && period_match && !zero_detect && !wr_count;
    endsequence

    sequence down_at_zero_s;
        tick && updn && dir_q && zero_detect && !wr_count;
    endsequence

    prop_free_wrap_a: assert property (@(posedge pclk) // R1
        disable iff (!presetn) tick && mode == MODE_FREE &&
        period_match && !wr_count |=> count_q == 0)
        else $error("free-running count did not wrap");
    single_stop_a: assert property (@(posedge pclk) // R2
        disable iff (!presetn) single_stop && !wr_ctrl && !wr_count
        |=> !run && count_q == 0)
        else $error("single event did not halt");
    updn_reverse_a: assert property (@(posedge pclk) // R3 R4
        disable iff (!presetn) up_at_period_s
        |=> dir_q)
        else $error("up/down did not reverse");
    dir_read_a: assert property (@(posedge pclk) // R4
        disable iff (!presetn) rd_en && paddr == OFF_COUNT
        |-> prdata[CNT_DIR_BIT] == dir_q)
        else $error("direction flag misread");
    ctrl_keeps_a: assert property (@(posedge pclk) // R9
        disable iff (!presetn) wr_ctrl
        |=> count_q == $past(count_q))
        else $error("control write moved count");
    pre_clear_a: assert property (@(posedge pclk) // R8 R14
        disable iff (!presetn) wr_ctrl || wr_count
        |=> pre_q == 0 && post_q == 0)
        else $error("scalers not cleared");
    stop_hold_a: assert property (@(posedge pclk) // R12
        disable iff (!presetn) !run && !wr_count
        |=> count_q == $past(count_q))
        else $error("stopped count changed");
    stop_load_a: assert property (@(posedge pclk) // R16
        disable iff (!presetn) !run ##1 !run
        |-> period_act_q == $past(period_buf_q))
        else $error("period not loaded while stopped");
    double_evt_a: assert property (@(posedge pclk) // R5 R18
        disable iff (!presetn) mode == MODE_UPDN2 && tick && zero_detect
        |=> status_q[ST_IRQ_BIT])
        else $error("double update event lost");
    up_step_a: assert property (@(posedge pclk) // R1 R19
        disable iff (!presetn) tick && !updn && !period_match && !wr_count
        |=> count_q == $past(count_q) + 1'b1)
        else $error("count did not step up");
    down_step_a: assert property (@(posedge pclk) // R3
        disable iff (!presetn) tick && updn && dir_q && !zero_detect &&
        !wr_count |=> count_q == $past(count_q) - 1'b1)
        else $error("count did not step down");
    updn_wrap_a: assert property (@(posedge pclk) // R3 R4
        disable iff (!presetn) down_at_zero_s
        |=> !dir_q && count_q == 1)
        else $error("up/down did not turn at zero");
    pre_space_a: assert property (@(posedge pclk) // R7 R19
        disable iff (!presetn) tick && pre_sel != 2'b00
        |=> !tick)
        else $error("prescaled steps too close");
    period_hold_a: assert property (@(posedge pclk) // R15
        disable iff (!presetn) run && !tick
        |=> period_act_q == $past(period_act_q))
        else $error("active period moved mid-cycle");
    adc_pulse_a: assert property (@(posedge pclk) // R17
        disable iff (!presetn) tick && count_q == evcmp_q
        |=> adc_trigger)
        else $error("event trigger missing");
    single_flag_a: assert property (@(posedge pclk) // R2 R18
        disable iff (!presetn) tick && mode == MODE_SINGLE && period_match
        |=> status_q[ST_IRQ_BIT])
        else $error("single event flag lost");
    post_limit_a: assert property (@(posedge pclk) // R13
        disable iff (!presetn) post_q <= post_sel)
        else $error("postscaler past its limit");

endmodule

`default_nettype wire
